// file: verilog/ase_setup_regs.vh
/*
 Constants for the ADC setup and excitation register bank: register indices,
 field positions, write masks, reset values and decoded current figures.
 Assumes a 32-bit AXI4-Lite slave with word-aligned registers, byte address = 4 * index.
*/
`ifndef ASE_SETUP_REGS_VH
`define ASE_SETUP_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ASE_SETUP_FIRST_INDEX 6'h19
`define ASE_SETUP_LAST_INDEX 6'h20
`define ASE_CHAN_FIRST_INDEX 6'h01
`define ASE_CHAN_LAST_INDEX 6'h10
`define ASE_SETUP_COUNT 8
`define ASE_CHAN_COUNT 16
`define ASE_PIN_COUNT 16

// ----------------------------------------------------------------
// Setup register fields
// ----------------------------------------------------------------
`define ASE_SECOND_MAG_HI 15
`define ASE_SECOND_MAG_LO 13
`define ASE_FIRST_MAG_HI 12
`define ASE_FIRST_MAG_LO 10
`define ASE_BURNOUT_HI 9
`define ASE_BURNOUT_LO 8
`define ASE_POS_BUF_BIT 7
`define ASE_NEG_BUF_BIT 3
`define ASE_SETUP_WMASK 16'hFF88
`define ASE_SETUP_RESET 16'h0000

// ----------------------------------------------------------------
// Channel register fields
// ----------------------------------------------------------------
`define ASE_FIRST_PIN_HI 3
`define ASE_FIRST_PIN_LO 0
`define ASE_SECOND_PIN_HI 7
`define ASE_SECOND_PIN_LO 4
`define ASE_SETUP_SEL_HI 10
`define ASE_SETUP_SEL_LO 8
`define ASE_CHAN_WMASK 16'h07FF
`define ASE_CHAN_RESET 16'h0000

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define ASE_RESP_OKAY 2'h0
`define ASE_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Excitation magnitude codes and currents in nanoamps
// ----------------------------------------------------------------
`define ASE_MAG_OFF 3'h0
`define ASE_MAG_10UA 3'h1
`define ASE_MAG_20UA 3'h2
`define ASE_MAG_50UA 3'h3
`define ASE_MAG_100UA 3'h4
`define ASE_MAG_150UA 3'h5
`define ASE_MAG_200UA 3'h6
`define ASE_MAG_100NA 3'h7
`define ASE_NA_OFF 18'h0_0000
`define ASE_NA_10UA 18'h0_2710
`define ASE_NA_20UA 18'h0_4E20
`define ASE_NA_50UA 18'h0_C350
`define ASE_NA_100UA 18'h1_86A0
`define ASE_NA_150UA 18'h2_49F0
`define ASE_NA_200UA 18'h3_0D40
`define ASE_NA_100NA 18'h0_0064

// ----------------------------------------------------------------
// Burnout codes and currents in nanoamps
// ----------------------------------------------------------------
`define ASE_BURN_OFF 2'h0
`define ASE_BURN_HALF_UA 2'h1
`define ASE_BURN_2UA 2'h2
`define ASE_BURN_4UA 2'h3
`define ASE_BURN_NA_OFF 13'h0000
`define ASE_BURN_NA_HALF_UA 13'h01F4
`define ASE_BURN_NA_2UA 13'h07D0
`define ASE_BURN_NA_4UA 13'h0FA0

`endif

// file: verilog/ase_excite_decode.v
/*
 Decoder for one excitation source: magnitude code to current in nanoamps,
 pin code to a one-hot pin enable. Purely combinational.
 Assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
`include "ase_setup_regs.vh"

module ase_excite_decode
(
   input wire [2:0] magnitude,
   input wire [3:0] pin_select,
   output reg [17:0] current_na,
   output wire [15:0] pin_enable
);

   // ----------------------------------------------------------------
   // Magnitude decode
   // ----------------------------------------------------------------
   always @*
   begin
      case (magnitude)
         `ASE_MAG_OFF: current_na = `ASE_NA_OFF;
         `ASE_MAG_10UA: current_na = `ASE_NA_10UA;
         `ASE_MAG_20UA: current_na = `ASE_NA_20UA;
         `ASE_MAG_50UA: current_na = `ASE_NA_50UA;
         `ASE_MAG_100UA: current_na = `ASE_NA_100UA;
         `ASE_MAG_150UA: current_na = `ASE_NA_150UA;
         `ASE_MAG_200UA: current_na = `ASE_NA_200UA;
         `ASE_MAG_100NA: current_na = `ASE_NA_100NA;
         default: current_na = `ASE_NA_OFF;
      endcase
   end

   // ----------------------------------------------------------------
   // Pin routing, only while the source is on
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `ASE_PIN_COUNT; i = i + 1)
      begin : g_pin
         localparam [31:0] PIN_NUM = i;
         localparam [3:0] PIN = PIN_NUM[3:0];
         assign pin_enable[i] = (pin_select == PIN) && (magnitude != `ASE_MAG_OFF);
      end
   endgenerate

endmodule // ase_excite_decode

// file: verilog/ase_setup_bank.v
/*
 ADC setup and excitation register bank: eight setup registers, sixteen
 channel routing registers, an AXI4-Lite slave and a conversion-start latch.
 Assumes one clock, synchronous active-low reset, and a sequencer that
 pulses conv_start with the channel number of the conversion it begins.
*/
// Behaviour
// - Eight setup registers sit at indices 0x19 to 0x20, one per setup.
// - Every setup register is all zeros after reset, sources off and buffers bypassed.
// - Bits 15:13 set the second source: off, 10/20/50/100/150/200 uA, and code 7 gives 100 nA.
// - Bits 12:10 set the first source with the same encoding, code 0 off.
// - Bits 9:8 set burnout: off, 0.5 uA, 2 uA, 4 uA.
// - Bit 7 switches the positive reference buffer on when set, bypassed when clear.
// - Bit 3 switches the negative reference buffer on when set, bypassed when clear.
// - Channel bits 3:0 route the first source to the analog input of that number.
// - The second pin field routes the second source to the input of that number, 0 to 15 included.
// - The second pin field is channel bits 7:4, read-write, reset zero.
// - A setup applies to a conversion only through the channel that selects it; channels may share one.
// - All setup and channel fields read back the last value written.
`timescale 1ns/1ps
`include "ase_setup_regs.vh"

module ase_setup_bank
(
   input wire aclk,
   input wire aresetn,
   input wire [7:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [7:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   input wire conv_start,
   input wire [3:0] conv_channel,
   output reg [2:0] active_setup,
   output reg [2:0] second_excitation_magnitude,
   output reg [2:0] first_excitation_magnitude,
   output reg [1:0] active_burnout,
   output reg [12:0] burnout_current_na,
   output reg pos_reference_buffer_on,
   output reg neg_reference_buffer_on,
   output reg [3:0] first_excitation_pin_select,
   output reg [3:0] second_excitation_pin_select,
   output reg [17:0] first_excitation_current_na,
   output reg [17:0] second_excitation_current_na,
   output reg [15:0] first_excitation_pin_enable,
   output reg [15:0] second_excitation_pin_enable
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg [15:0] setup_reg [0:`ASE_SETUP_COUNT-1];
   reg [15:0] chan_reg [0:`ASE_CHAN_COUNT-1];

   // ----------------------------------------------------------------
   // Write channel capture
   // ----------------------------------------------------------------
   reg aw_held;
   reg [7:0] aw_addr_q;
   reg w_held;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire do_write;
   wire [5:0] wr_index;
   wire wr_aligned;
   wire wr_is_setup;
   wire wr_is_chan;
   wire [2:0] wr_setup_slot;
   wire [3:0] wr_chan_slot;
   wire [15:0] wr_lane_mask;

   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign do_write = aw_held && w_held && !bvalid;

   assign wr_index = aw_addr_q[7:2];
   assign wr_aligned = (aw_addr_q[1:0] == 2'h0);
   assign wr_is_setup = wr_aligned && (wr_index >= `ASE_SETUP_FIRST_INDEX) &&
      (wr_index <= `ASE_SETUP_LAST_INDEX);
   assign wr_is_chan = wr_aligned && (wr_index >= `ASE_CHAN_FIRST_INDEX) &&
      (wr_index <= `ASE_CHAN_LAST_INDEX);
   assign wr_setup_slot = wr_index[2:0] - 3'h1;
   assign wr_chan_slot = wr_index[3:0] - 4'h1;
   assign wr_lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr_q <= 8'h00;
      end
      else if (awvalid && awready)
      begin
         aw_held <= 1'b1;
         aw_addr_q <= awaddr;
      end
      else if (do_write)
      begin
         aw_held <= 1'b0;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end
      else if (wvalid && wready)
      begin
         w_held <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end
      else if (do_write)
      begin
         w_held <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Write response
   // ----------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= `ASE_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         bresp <= (wr_is_setup || wr_is_chan) ? `ASE_RESP_OKAY : `ASE_RESP_SLVERR;
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Setup registers
   // ----------------------------------------------------------------
   genvar s;
   generate
      for (s = 0; s < `ASE_SETUP_COUNT; s = s + 1)
      begin : g_setup
         localparam [31:0] SLOT_NUM = s;
         localparam [2:0] SLOT = SLOT_NUM[2:0];
         always @(posedge aclk)
         begin
            if (!aresetn)
               setup_reg[s] <= `ASE_SETUP_RESET;
            else if (do_write && wr_is_setup && (wr_setup_slot == SLOT))
               setup_reg[s] <= ((setup_reg[s] & ~wr_lane_mask) | (w_data_q[15:0] & wr_lane_mask)) &
                  `ASE_SETUP_WMASK;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Channel registers
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < `ASE_CHAN_COUNT; c = c + 1)
      begin : g_chan
         localparam [31:0] SLOT_NUM = c;
         localparam [3:0] SLOT = SLOT_NUM[3:0];
         always @(posedge aclk)
         begin
            if (!aresetn)
               chan_reg[c] <= `ASE_CHAN_RESET;
            else if (do_write && wr_is_chan && (wr_chan_slot == SLOT))
               chan_reg[c] <= ((chan_reg[c] & ~wr_lane_mask) | (w_data_q[15:0] & wr_lane_mask)) &
                  `ASE_CHAN_WMASK;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   wire [5:0] rd_index;
   wire rd_aligned;
   wire rd_is_setup;
   wire rd_is_chan;
   wire [2:0] rd_setup_slot;
   wire [3:0] rd_chan_slot;
   reg [15:0] rd_value;

   assign arready = !rvalid;
   assign rd_index = araddr[7:2];
   assign rd_aligned = (araddr[1:0] == 2'h0);
   assign rd_is_setup = rd_aligned && (rd_index >= `ASE_SETUP_FIRST_INDEX) &&
      (rd_index <= `ASE_SETUP_LAST_INDEX);
   assign rd_is_chan = rd_aligned && (rd_index >= `ASE_CHAN_FIRST_INDEX) &&
      (rd_index <= `ASE_CHAN_LAST_INDEX);
   assign rd_setup_slot = rd_index[2:0] - 3'h1;
   assign rd_chan_slot = rd_index[3:0] - 4'h1;

   always @*
   begin
      if (rd_is_setup)
         rd_value = setup_reg[rd_setup_slot];
      else if (rd_is_chan)
         rd_value = chan_reg[rd_chan_slot];
      else
         rd_value = 16'h0000;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `ASE_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata <= {16'h0000, rd_value};
         rresp <= (rd_is_setup || rd_is_chan) ? `ASE_RESP_OKAY : `ASE_RESP_SLVERR;
      end
      else if (rready)
      begin
         rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Selection for the conversion about to start
   // ----------------------------------------------------------------
   wire [15:0] sel_chan;
   wire [2:0] sel_setup_slot;
   wire [15:0] sel_setup;
   wire [2:0] sel_second_mag;
   wire [2:0] sel_first_mag;
   wire [1:0] sel_burnout;
   wire [3:0] sel_first_pin;
   wire [3:0] sel_second_pin;
   wire [17:0] dec_first_na;
   wire [17:0] dec_second_na;
   wire [15:0] dec_first_enable;
   wire [15:0] dec_second_enable;
   reg [12:0] dec_burnout_na;

   assign sel_chan = chan_reg[conv_channel];
   assign sel_setup_slot = sel_chan[`ASE_SETUP_SEL_HI:`ASE_SETUP_SEL_LO];
   assign sel_setup = setup_reg[sel_setup_slot];
   assign sel_second_mag = sel_setup[`ASE_SECOND_MAG_HI:`ASE_SECOND_MAG_LO];
   assign sel_first_mag = sel_setup[`ASE_FIRST_MAG_HI:`ASE_FIRST_MAG_LO];
   assign sel_burnout = sel_setup[`ASE_BURNOUT_HI:`ASE_BURNOUT_LO];
   assign sel_first_pin = sel_chan[`ASE_FIRST_PIN_HI:`ASE_FIRST_PIN_LO];
   assign sel_second_pin = sel_chan[`ASE_SECOND_PIN_HI:`ASE_SECOND_PIN_LO];

   ase_excite_decode u_first
   (
      .magnitude(sel_first_mag),
      .pin_select(sel_first_pin),
      .current_na(dec_first_na),
      .pin_enable(dec_first_enable)
   );

   ase_excite_decode u_second
   (
      .magnitude(sel_second_mag),
      .pin_select(sel_second_pin),
      .current_na(dec_second_na),
      .pin_enable(dec_second_enable)
   );

   always @*
   begin
      case (sel_burnout)
         `ASE_BURN_OFF: dec_burnout_na = `ASE_BURN_NA_OFF;
         `ASE_BURN_HALF_UA: dec_burnout_na = `ASE_BURN_NA_HALF_UA;
         `ASE_BURN_2UA: dec_burnout_na = `ASE_BURN_NA_2UA;
         `ASE_BURN_4UA: dec_burnout_na = `ASE_BURN_NA_4UA;
         default: dec_burnout_na = `ASE_BURN_NA_OFF;
      endcase
   end

   // ----------------------------------------------------------------
   // Active settings, held for the whole conversion
   // ----------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         active_setup <= 3'h0;
         second_excitation_magnitude <= `ASE_MAG_OFF;
         first_excitation_magnitude <= `ASE_MAG_OFF;
         active_burnout <= `ASE_BURN_OFF;
         burnout_current_na <= `ASE_BURN_NA_OFF;
         pos_reference_buffer_on <= 1'b0;
         neg_reference_buffer_on <= 1'b0;
         first_excitation_pin_select <= 4'h0;
         second_excitation_pin_select <= 4'h0;
         first_excitation_current_na <= `ASE_NA_OFF;
         second_excitation_current_na <= `ASE_NA_OFF;
         first_excitation_pin_enable <= 16'h0000;
         second_excitation_pin_enable <= 16'h0000;
      end
      else if (conv_start)
      begin
         active_setup <= sel_setup_slot;
         second_excitation_magnitude <= sel_second_mag;
         first_excitation_magnitude <= sel_first_mag;
         active_burnout <= sel_burnout;
         burnout_current_na <= dec_burnout_na;
         pos_reference_buffer_on <= sel_setup[`ASE_POS_BUF_BIT];
         neg_reference_buffer_on <= sel_setup[`ASE_NEG_BUF_BIT];
         first_excitation_pin_select <= sel_first_pin;
         second_excitation_pin_select <= sel_second_pin;
         first_excitation_current_na <= dec_first_na;
         second_excitation_current_na <= dec_second_na;
         first_excitation_pin_enable <= dec_first_enable;
         second_excitation_pin_enable <= dec_second_enable;
      end
   end

endmodule // ase_setup_bank

// file: test/ase_setup_chk.sv
/*
 Checker for the ports of the setup and excitation register bank.
 Assumes one clock aclk and synchronous active-low reset aresetn.
*/
`timescale 1ns/1ps
module ase_setup_chk
(
   input wire aclk,
   input wire aresetn,
   input wire [1:0] bresp,
   input wire bvalid,
   input wire bready,
   input wire arready,
   input wire [31:0] rdata,
   input wire rvalid,
   input wire rready,
   input wire conv_start,
   input wire [2:0] active_setup,
   input wire [2:0] first_excitation_magnitude,
   input wire [2:0] second_excitation_magnitude,
   input wire [1:0] active_burnout,
   input wire [12:0] burnout_current_na,
   input wire [3:0] first_excitation_pin_select,
   input wire [3:0] second_excitation_pin_select,
   input wire [17:0] first_excitation_current_na,
   input wire [17:0] second_excitation_current_na,
   input wire [15:0] first_excitation_pin_enable,
   input wire [15:0] second_excitation_pin_enable
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------------------------------
   // Current tables
   // ----------------------------------------------------------------
   function automatic logic [17:0] na(input logic [2:0] c);
      case (c)
         3'h1: na = 18'h0_2710;
         3'h2: na = 18'h0_4E20;
         3'h3: na = 18'h0_C350;
         3'h4: na = 18'h1_86A0;
         3'h5: na = 18'h2_49F0;
         3'h6: na = 18'h3_0D40;
         3'h7: na = 18'h0_0064;
         default: na = 18'h0_0000;
      endcase
   endfunction
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   chk_r_upper: assert property (rvalid |-> rdata[31:16] == 16'h0000 && !arready)
      else $error("read upper half or arready wrong");
   chk_act_hold: assert property (!conv_start |=> $stable({active_setup, first_excitation_magnitude,
      second_excitation_magnitude, active_burnout, first_excitation_pin_select, second_excitation_pin_select}))
      else $error("active settings moved without conversion start");
   chk_first_pin: assert property (first_excitation_pin_enable ==
      (first_excitation_magnitude != 3'h0 ? 16'h0001 << first_excitation_pin_select : 16'h0000))
      else $error("first pin enable wrong");
   chk_second_pin: assert property (second_excitation_pin_enable ==
      (second_excitation_magnitude != 3'h0 ? 16'h0001 << second_excitation_pin_select : 16'h0000))
      else $error("second pin enable wrong");
   chk_first_na: assert property (first_excitation_current_na == na(first_excitation_magnitude))
      else $error("first current wrong");
   chk_second_na: assert property (second_excitation_current_na == na(second_excitation_magnitude))
      else $error("second current wrong");
   chk_burn_na: assert property (burnout_current_na == (active_burnout == 2'h0 ? 13'h0000 :
      active_burnout == 2'h1 ? 13'h01F4 : active_burnout == 2'h2 ? 13'h07D0 : 13'h0FA0))
      else $error("burnout current wrong");
endmodule // ase_setup_chk
bind ase_setup_bank ase_setup_chk ase_setup_chk_i (.aclk, .aresetn, .bresp, .bvalid, .bready, .arready, .rdata,
   .rvalid, .rready, .conv_start, .active_setup, .first_excitation_magnitude, .second_excitation_magnitude,
   .active_burnout, .burnout_current_na, .first_excitation_pin_select, .second_excitation_pin_select,
   .first_excitation_current_na, .second_excitation_current_na, .first_excitation_pin_enable,
   .second_excitation_pin_enable);

// file: test/ase_host_model.sv
/*
 Host side model: an AXI4-Lite master with one write and one read task.
 Assumes the slave answers in its own time; the bench timeout ends a hang.
*/
`timescale 1ns/1ps
module ase_host_model
(
   input wire aclk,
   output logic [7:0] awaddr = 8'h00,
   output logic awvalid = 1'b0,
   input wire awready,
   output logic [31:0] wdata = 32'h0000_0000,
   output logic [3:0] wstrb = 4'hF,
   output logic wvalid = 1'b0,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   output logic bready = 1'b0,
   output logic [7:0] araddr = 8'h00,
   output logic arvalid = 1'b0,
   input wire arready,
   input wire [31:0] rdata,
   input wire [1:0] rresp,
   input wire rvalid,
   output logic rready = 1'b0
);
   // ----------------------------------------------------------------
   // Bus tasks, released payload shows the inverse
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready)
         begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready)
         begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (bvalid && bready)
         begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!(rvalid && rready))
      begin
         @(posedge aclk);
         if (arvalid && arready)
         begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // ase_host_model

// file: test/tb.sv
/*
 Self-checking bench for the setup and excitation register bank.
 Assumes the host model on the register bus and the bench as sequencer.
*/
`timescale 1ns/1ps
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic conv_start = 1'b0;
   logic [3:0] conv_channel = 4'h0;
   wire [7:0] awaddr, araddr;
   wire [31:0] wdata, rdata;
   wire [3:0] wstrb, fpin, spin;
   wire [1:0] bresp, rresp, burn;
   wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, pbuf, nbuf;
   wire [2:0] act, fm, sm;
   wire [12:0] bna;
   wire [17:0] fna, sna;
   wire [15:0] fen, sen;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} ase_row;
   ase_row rows [7];
   integer errors = 0, checks = 0, cycles = 0, i;
   logic [31:0] d;
   logic [1:0] r;
   logic [2:0] s;
   logic [3:0] c;
   always #2.5 aclk = ~aclk;
   ase_host_model ase_host_model_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   ase_setup_bank ase_setup_bank_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .conv_start(conv_start), .conv_channel(conv_channel),
      .active_setup(act), .second_excitation_magnitude(sm), .first_excitation_magnitude(fm),
      .active_burnout(burn), .burnout_current_na(bna), .pos_reference_buffer_on(pbuf),
      .neg_reference_buffer_on(nbuf), .first_excitation_pin_select(fpin), .second_excitation_pin_select(spin),
      .first_excitation_current_na(fna), .second_excitation_current_na(sna),
      .first_excitation_pin_enable(fen), .second_excitation_pin_enable(sen));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] na(input logic [2:0] k);
      logic [31:0] t [8] = '{0, 10000, 20000, 50000, 100000, 150000, 200000, 100};
      na = t[k];
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conv(input logic [3:0] ch);
      @(posedge aclk);
      conv_start <= 1'b1;
      conv_channel <= ch;
      @(posedge aclk);
      conv_start <= 1'b0;
      @(negedge aclk);
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors = errors + 1;
         test_done;
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rows = '{'{8'h64, 32'hFFFF_FFFF, 32'h0000_FF88, 2'h0}, '{8'h80, 32'h0000_2588, 32'h0000_2588, 2'h0},
         '{8'h62, 32'h0000_1111, 32'h0000_0000, 2'h2}, '{8'h84, 32'h0000_2222, 32'h0000_0000, 2'h2},
         '{8'h00, 32'h0000_3333, 32'h0000_0000, 2'h2}, '{8'h04, 32'h0000_FFFF, 32'h0000_07FF, 2'h0},
         '{8'h40, 32'h0000_F5A3, 32'h0000_05A3, 2'h0}};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 24; i++)
      begin
         ase_host_model_i.rd(i < 8 ? 8'(8'h64 + 4 * i) : 8'(8'h04 + 4 * (i - 8)), d, r);
         chk(d, 32'h0000_0000);
      end
      foreach (rows[k])
      begin
         ase_host_model_i.wr(rows[k].a, rows[k].d, r);
         chk(r, rows[k].r);
         ase_host_model_i.rd(rows[k].a, d, r);
         chk(d, rows[k].e);
         chk(r, rows[k].r);
      end
      for (i = 0; i < 16; i++)
      begin
         s = i[2:0];
         c = i[3:0];
         if (i < 8)
            ase_host_model_i.wr(8'(8'h64 + 4 * i), {16'h0, s, 3'h7 - s, s[1:0], s[0], 3'h0, s[1], 3'h0}, r);
         ase_host_model_i.wr(8'(8'h04 + 4 * i), {21'h0, s, 4'hF - c, c}, r);
      end
      for (i = 0; i < 16; i++)
      begin
         s = i[2:0];
         c = i[3:0];
         conv(c);
         chk(act, s);
         chk(sm, s);
         chk(fm, 3'h7 - s);
         chk(sna, na(s));
         chk(fna, na(3'h7 - s));
         chk(burn, s[1:0]);
         chk(bna, s[1:0] == 2'h0 ? 32'h0 : s[1:0] == 2'h1 ? 32'h01F4 : s[1:0] == 2'h2 ? 32'h07D0 : 32'h0FA0);
         chk(fpin, c);
         chk(pbuf, s[0]);
         chk(nbuf, s[1]);
         chk(fen, s != 3'h7 ? 16'h1 << c : 16'h0);
         chk(sen, s != 3'h0 ? 16'h1 << (4'hF - c) : 16'h0);
         chk(spin, 4'hF - c);
      end
      ase_host_model_i.wr(8'h80, 32'h0000_0000, r);
      chk(sm, 3'h7);
      conv(4'hF);
      chk(sm, 3'h0);
      chk(sen, 16'h0000);
      @(posedge aclk);
      conv_start <= 1'b1;
      conv_channel <= 4'h1;
      @(posedge aclk);
      conv_channel <= 4'h2;
      @(negedge aclk);
      chk(act, 3'h1);
      @(posedge aclk);
      conv_start <= 1'b0;
      @(negedge aclk);
      chk(act, 3'h2);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(act, 3'h0);
      ase_host_model_i.rd(8'h68, d, r);
      chk(d, 32'h0000_0000);
      test_done;
   end
endmodule // tb
